// ---- inc/hb_prot_cfg.svh ----
// timing, field and address constants for the half-bridge protection supervisor
`ifndef HB_PROT_CFG_SVH
`define HB_PROT_CFG_SVH
// clock rate in MHz (40 MHz, 25 ns)
`define CLK_MHZ          40
// dead time choices in ns
`define DEAD_NS_0        120
`define DEAD_NS_1        240
`define DEAD_NS_2        480
`define DEAD_NS_3        960
`define DEAD_NS_FIXED    240
// least dead-time counts, rounded up
`define DEAD_CYC(ns)     ((((ns) * `CLK_MHZ) + 999) / 1000)
// watchdog fault pulse length in us, converted exactly to cycles
`define WDOG_PULSE_US    64
`define WDOG_PULSE_CYC   (`WDOG_PULSE_US * `CLK_MHZ)
// trip select code that disables the drain monitor
`define TRIP_DISABLED    3'h5
// register map (byte addresses), own choice except status at 0x00
`define ADDR_STATUS      12'h000
`define ADDR_CTRL        12'h004
`define ADDR_CFG         12'h008
// status field positions
`define ST_SUMMARY       7
`define ST_WDOG          6
`define ST_GATE          5
`define ST_OC            4
`define ST_SUPPLY        3
`define ST_PUMP          2
`define ST_OTEMP         1
`define ST_OTW           0
// control fields
`define CTRL_CLEAR       0
`define CTRL_WDOG_EN     1
// config fields
`define CFG_DEAD_LO      0
`define CFG_WDOG_LO      2
`endif

// ---- inc/hb_prot_pkg.sv ----
// types for the half-bridge protection supervisor
package hb_prot_pkg;
    // live fault conditions from analog comparators
    typedef struct packed {
        logic supply_lockout;
        logic pump_undervoltage;
        logic thermal_shutdown;
        logic overtemp_warn;
        logic sense_oc;
        logic drain_trip_hs;
        logic drain_trip_ls;
        logic high_gate_ok;
        logic low_gate_ok;
    } sense_t;
    // bridge drive commands
    typedef struct packed {
        logic high_on;
        logic low_on;
    } drive_t;
    // dead-time phases
    typedef enum logic [1:0] {ph_off, ph_dead, ph_high, ph_low} phase_t;
endpackage

// ---- verilog/hb_prot.sv ----
// half-bridge dead time, fault supervisor and watchdog with apb registers
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "hb_prot_cfg.svh"

// Contract
// - selectable dead time 120/240/480/960 ns
// - fixed variant uses 240 ns dead time
// - hold node undriven until gate below threshold
// - deglitch the control inputs
// - overcurrent only after drain trip deglitch
// - six trip codes, top code disables monitor
// - supply undervoltage disables bridge and pump
// - supply lockout keeps configuration
// - logic lockout resets everything, fault low
// - pump undervoltage disables bridge, pump runs
// - overcurrent disables then retries after time
// - retry repeats, flag sticks until clear
// - sense overcurrent sets flag, fault low
// - gate not slewed in time is fault
// - overtemp disables all, resumes after cooling
// - auto recovery keeps flag until clear
// - watchdog off at reset, enabled by write
// - status read restarts watchdog timer
// - expiry pulses wdog fault 64 us
// - timeout halts bridge until clear
// - summary flag ors flags except warning
module hb_prot #(
    parameter int  CONFIGURABLE  = 1,
    parameter int  GLITCH_CYC    = 4,
    parameter int  OC_DEGLITCH   = 160,
    parameter int  RETRY_CYC     = 120000,
    parameter int  DRIVE_CYC     = 160,
    parameter int  WDOG_UNIT     = 400000,
    parameter int  PULSE_CYC     = `WDOG_PULSE_CYC
) (
    // clock and logic-lockout reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // pwm control inputs and sense comparators
    input  wire logic                 high_cmd,
    input  wire logic                 low_cmd,
    input  wire logic [2:0]           trip_threshold_select,
    input  wire hb_prot_pkg::sense_t  sense,
    // gate drive and status outputs
    output hb_prot_pkg::drive_t       drive,
    output logic [2:0]                trip_level,
    output logic                      pump_enable,
    output logic                      regulator_enable,
    output logic                      fault_out_n,
    output logic                      wdog_fault_out_n
);
    // ==========================================================
    // elaboration checks
    if (GLITCH_CYC < 1 || GLITCH_CYC > 256 || OC_DEGLITCH < 1 || RETRY_CYC < 1 || DRIVE_CYC < 1
        || WDOG_UNIT < 1 || PULSE_CYC < 1) begin : g_bad_counts
        $error("hb_prot: counts out of range");
    end

    localparam logic [9:0] DEAD0 = 10'(`DEAD_CYC(`DEAD_NS_0));
    localparam logic [9:0] DEAD1 = 10'(`DEAD_CYC(`DEAD_NS_1));
    localparam logic [9:0] DEAD2 = 10'(`DEAD_CYC(`DEAD_NS_2));
    localparam logic [9:0] DEAD3 = 10'(`DEAD_CYC(`DEAD_NS_3));
    localparam logic [9:0] DEADF = 10'(`DEAD_CYC(`DEAD_NS_FIXED));

    // dead-time count for a select code
    function automatic logic [9:0] dead_of(input logic [1:0] s);
        unique case (s)
            2'h0: dead_of = DEAD0;
            2'h1: dead_of = DEAD1;
            2'h2: dead_of = DEAD2;
            2'h3: dead_of = DEAD3;
        endcase
    endfunction

    // ==========================================================
    // registers
    logic [1:0]  dead_sel_reg;        // dead time select
    logic [1:0]  wdog_interval_field; // watchdog interval
    logic        wdog_enable_bit;     // watchdog enable
    logic        wdog_timeout_flag;   // sticky flags
    logic        gate_fault_flag;
    logic        overcurrent_flag;
    logic        supply_uv_flag;
    logic        pump_uv_flag;
    logic        overtemp_flag;
    logic        overtemp_warning_flag;
    logic        summary;             // or of fault flags
    logic        acc;                 // apb access phase
    logic        fault_clear_bit;     // one-cycle clear pulse
    logic        status_read;         // status read taken

    assign acc             = psel && penable;
    assign fault_clear_bit = acc && pwrite && paddr == `ADDR_CTRL && pwdata[`CTRL_CLEAR];
    assign status_read     = acc && !pwrite && paddr == `ADDR_STATUS;
    assign summary         = wdog_timeout_flag | gate_fault_flag | overcurrent_flag | supply_uv_flag
                           | pump_uv_flag | overtemp_flag;

    // ==========================================================
    // input deglitch: a level must hold GLITCH_CYC cycles
    logic [1:0]  cmd_reg;
    logic [7:0]  glitch_cnt_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_reg        <= 2'h0;
            glitch_cnt_reg <= 8'h00;
        end else if ({high_cmd, low_cmd} == cmd_reg) begin
            glitch_cnt_reg <= 8'h00;
        end else if (glitch_cnt_reg >= 8'(GLITCH_CYC - 1)) begin
            cmd_reg        <= {high_cmd, low_cmd};
            glitch_cnt_reg <= 8'h00;
        end else begin
            glitch_cnt_reg <= glitch_cnt_reg + 8'h01;
        end
    end

    // ==========================================================
    // fault responses
    logic oc_now, gate_now, retry_active_reg, bridge_block, pump_block, wdog_halt_reg;
    logic [$clog2(RETRY_CYC+1)-1:0] retry_cnt_reg;
    logic [$clog2(OC_DEGLITCH+1)-1:0] oc_cnt_reg;
    logic [$clog2(DRIVE_CYC+1)-1:0] drv_cnt_reg;
    logic monitor_on, drain_trip;

    assign monitor_on = trip_threshold_select < `TRIP_DISABLED;
    assign drain_trip = monitor_on && ((drive.high_on && sense.drain_trip_hs) || (drive.low_on && sense.drain_trip_ls));
    assign oc_now     = (drain_trip && oc_cnt_reg == ($bits(oc_cnt_reg))'(OC_DEGLITCH)) || sense.sense_oc;
    assign gate_now   = drv_cnt_reg == ($bits(drv_cnt_reg))'(DRIVE_CYC);
    assign bridge_block = sense.supply_lockout || sense.pump_undervoltage || sense.thermal_shutdown
                        || retry_active_reg || wdog_halt_reg;
    assign pump_block   = sense.supply_lockout || sense.thermal_shutdown;

    // drain trip must persist past the deglitch count
    always_ff @(posedge clk) begin
        if (!rst_n || !drain_trip)
            oc_cnt_reg <= '0;
        else if (oc_cnt_reg != ($bits(oc_cnt_reg))'(OC_DEGLITCH))
            oc_cnt_reg <= oc_cnt_reg + 1'b1;
    end

    // gate slew watch: gate must reach its level within the drive interval
    always_ff @(posedge clk) begin
        if (!rst_n || (drive.high_on ? sense.high_gate_ok : drive.low_on ? sense.low_gate_ok : 1'b1))
            drv_cnt_reg <= '0;
        else if (!gate_now)
            drv_cnt_reg <= drv_cnt_reg + 1'b1;
    end

    // retry timer: starts on an overcurrent or gate fault while idle; faults during a retry do not re-arm it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            retry_active_reg <= 1'b0;
            retry_cnt_reg    <= '0;
        end else if ((oc_now || gate_now) && !retry_active_reg) begin
            retry_active_reg <= 1'b1;
            retry_cnt_reg    <= '0;
        end else if (retry_active_reg) begin
            if (retry_cnt_reg == ($bits(retry_cnt_reg))'(RETRY_CYC - 1))
                retry_active_reg <= 1'b0;
            retry_cnt_reg <= retry_cnt_reg + 1'b1;
        end
    end

    // sticky flags: set wins over clear; clear only drops ended causes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_fault_flag       <= 1'b0;
            overcurrent_flag      <= 1'b0;
            supply_uv_flag        <= 1'b0;
            pump_uv_flag          <= 1'b0;
            overtemp_flag         <= 1'b0;
            overtemp_warning_flag <= 1'b0;
        end else begin
            gate_fault_flag       <= gate_now || (gate_fault_flag && !fault_clear_bit);
            overcurrent_flag      <= oc_now || (overcurrent_flag && !fault_clear_bit);
            supply_uv_flag        <= sense.supply_lockout || (supply_uv_flag && !fault_clear_bit);
            pump_uv_flag          <= sense.pump_undervoltage || (pump_uv_flag && !fault_clear_bit);
            overtemp_flag         <= sense.thermal_shutdown || (overtemp_flag && !fault_clear_bit);
            overtemp_warning_flag <= sense.overtemp_warn || (overtemp_warning_flag && !fault_clear_bit);
        end
    end

    // ==========================================================
    // watchdog
    logic [31:0] wdog_cnt_reg;
    logic [31:0] wdog_limit;
    logic [$clog2(PULSE_CYC+1)-1:0] pulse_cnt_reg;
    logic wdog_expire;
    assign wdog_limit  = 32'(WDOG_UNIT) << wdog_interval_field;
    assign wdog_expire = wdog_enable_bit && wdog_cnt_reg >= wdog_limit - 32'h1;

    // interval timer, restarted by each status read
    always_ff @(posedge clk) begin
        if (!rst_n || !wdog_enable_bit || status_read)
            wdog_cnt_reg <= 32'h0;
        else
            wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
    end

    // timeout flag and halt hold until clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdog_timeout_flag <= 1'b0;
            wdog_halt_reg     <= 1'b0;
        end else if (wdog_expire) begin
            wdog_timeout_flag <= 1'b1;
            wdog_halt_reg     <= 1'b1;
        end else if (fault_clear_bit) begin
            wdog_timeout_flag <= 1'b0;
            wdog_halt_reg     <= 1'b0;
        end
    end

    // low pulse on the watchdog fault pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pulse_cnt_reg    <= '0;
            wdog_fault_out_n <= 1'b1;
        end else if (wdog_expire) begin
            pulse_cnt_reg    <= ($bits(pulse_cnt_reg))'(PULSE_CYC - 1);
            wdog_fault_out_n <= 1'b0;
        end else if (pulse_cnt_reg != '0) begin
            pulse_cnt_reg    <= pulse_cnt_reg - 1'b1;
        end else begin
            wdog_fault_out_n <= 1'b1;
        end
    end

    // ==========================================================
    // configuration registers: kept through supply lockout
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dead_sel_reg        <= 2'h1;
            wdog_interval_field <= 2'h0;
            wdog_enable_bit     <= 1'b0;
        end else if (wdog_expire) begin
            wdog_enable_bit     <= 1'b0;
        end else if (acc && pwrite && paddr == `ADDR_CTRL) begin
            wdog_enable_bit     <= pwdata[`CTRL_WDOG_EN];
        end else if (acc && pwrite && paddr == `ADDR_CFG) begin
            dead_sel_reg        <= pwdata[`CFG_DEAD_LO +: 2];
            wdog_interval_field <= pwdata[`CFG_WDOG_LO +: 2];
        end
    end

    // apb answer: zero wait states, unmapped reads zero with error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr != `ADDR_STATUS && paddr != `ADDR_CTRL && paddr != `ADDR_CFG;
            unique case (paddr)
                `ADDR_STATUS: prdata <= {24'h0, summary, wdog_timeout_flag, gate_fault_flag, overcurrent_flag,
                                         supply_uv_flag, pump_uv_flag, overtemp_flag, overtemp_warning_flag};
                `ADDR_CTRL:   prdata <= {30'h0, wdog_enable_bit, 1'b0};
                `ADDR_CFG:    prdata <= {28'h0, wdog_interval_field, dead_sel_reg};
                default:      prdata <= 32'h0;
            endcase
        end
    end

    // ==========================================================
    // dead-time sequencer
    hb_prot_pkg::phase_t phase_reg;
    logic [9:0] dead_cnt_reg;
    logic [9:0] dead_len;
    logic       gates_low;
    assign dead_len  = (CONFIGURABLE != 0) ? dead_of(dead_sel_reg) : DEADF;
    assign gates_low = !sense.high_gate_ok && !sense.low_gate_ok;

    // high and low never on together; dead gap between them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_reg    <= hb_prot_pkg::ph_off;
            dead_cnt_reg <= 10'h0;
        end else if (bridge_block || cmd_reg == 2'h3 || cmd_reg == 2'h0) begin
            phase_reg    <= hb_prot_pkg::ph_dead;
            dead_cnt_reg <= 10'h0;
        end else begin
            unique case (phase_reg)
                hb_prot_pkg::ph_off, hb_prot_pkg::ph_dead: begin
                    if (dead_cnt_reg < dead_len - 10'h1)
                        dead_cnt_reg <= dead_cnt_reg + 10'h1;
                    else if (gates_low)
                        phase_reg <= cmd_reg[1] ? hb_prot_pkg::ph_high : hb_prot_pkg::ph_low;
                end
                hb_prot_pkg::ph_high: if (!cmd_reg[1]) begin
                    phase_reg    <= hb_prot_pkg::ph_dead;
                    dead_cnt_reg <= 10'h0;
                end
                hb_prot_pkg::ph_low: if (!cmd_reg[0]) begin
                    phase_reg    <= hb_prot_pkg::ph_dead;
                    dead_cnt_reg <= 10'h0;
                end
            endcase
        end
    end

    // registered pin outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive            <= '0;
            trip_level       <= 3'h0;
            pump_enable      <= 1'b0;
            regulator_enable <= 1'b0;
            fault_out_n      <= 1'b0;
        end else begin
            drive.high_on    <= phase_reg == hb_prot_pkg::ph_high && !bridge_block;
            drive.low_on     <= phase_reg == hb_prot_pkg::ph_low && !bridge_block;
            trip_level       <= trip_threshold_select;
            pump_enable      <= !pump_block;
            regulator_enable <= !sense.thermal_shutdown;
            fault_out_n      <= !(bridge_block || oc_now || gate_now);
        end
    end

    // ==========================================================
    // assertions
    a_no_overlap: assert property (@(posedge clk) disable iff (!rst_n)
        !(drive.high_on && drive.low_on)) else $error("both gates driven");
    a_supply_off: assert property (@(posedge clk) disable iff (!rst_n)
        sense.supply_lockout |=> !drive.high_on && !drive.low_on && !pump_enable && !fault_out_n) else $error("supply uv response");
    a_pump_uv: assert property (@(posedge clk) disable iff (!rst_n)
        sense.pump_undervoltage |=> !fault_out_n && pump_uv_flag) else $error("pump uv response");
    a_oc_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        overcurrent_flag && !fault_clear_bit |=> overcurrent_flag) else $error("oc flag dropped");
    a_sense_oc: assert property (@(posedge clk) disable iff (!rst_n)
        sense.sense_oc |=> overcurrent_flag && !fault_out_n) else $error("sense oc missed");
    a_summary_or: assert property (@(posedge clk) disable iff (!rst_n)
        pready && paddr == `ADDR_STATUS |-> prdata[`ST_SUMMARY] == (|prdata[`ST_WDOG:`ST_OTEMP]))
        else $error("summary mismatch");
    a_wdog_expiry: assert property (@(posedge clk) disable iff (!rst_n)
        wdog_expire |=> !wdog_fault_out_n && !wdog_enable_bit && wdog_timeout_flag) else $error("expiry response");
    a_wdog_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(wdog_fault_out_n) && !wdog_expire |=> !wdog_fault_out_n [*8]) else $error("wdog pulse short");
    a_wdog_halt: assert property (@(posedge clk) disable iff (!rst_n)
        wdog_halt_reg |=> !drive.high_on && !drive.low_on) else $error("halt leaks drive");
    a_read_restart: assert property (@(posedge clk) disable iff (!rst_n)
        status_read |=> wdog_cnt_reg == 32'h0) else $error("read no restart");
    a_otemp: assert property (@(posedge clk) disable iff (!rst_n)
        sense.thermal_shutdown |=> !regulator_enable && overtemp_flag) else $error("otemp response");
    c_oc_retry: cover property (@(posedge clk) disable iff (!rst_n) $fell(retry_active_reg));
    c_wdog_trip: cover property (@(posedge clk) disable iff (!rst_n) wdog_expire);
    c_high_on: cover property (@(posedge clk) disable iff (!rst_n) drive.high_on);
    c_clear: cover property (@(posedge clk) disable iff (!rst_n) fault_clear_bit && overcurrent_flag);
endmodule // hb_prot

// ---- verif/hb_fet_model.sv ----
// behavioural mosfet pair: gate charge follows the drive commands
`timescale 1ns/10ps
module hb_fet_model #(
    parameter int SLEW = 4
) (
    // clock and gate commands
    input  wire logic                clk,
    input  wire hb_prot_pkg::drive_t drive,
    // hold both gates uncharged, a shorted gate
    input  wire logic                stuck,
    // gate above threshold
    output logic                     high_gate_ok,
    output logic                     low_gate_ok
);
    int hi_cnt = 0;  // high gate charge level
    int lo_cnt = 0;  // low gate charge level

    // charge while driven, discharge otherwise; a short never charges
    always_ff @(posedge clk) begin
        hi_cnt <= (drive.high_on && !stuck) ? ((hi_cnt < SLEW) ? hi_cnt + 1 : SLEW) : ((hi_cnt > 0) ? hi_cnt - 1 : 0);
        lo_cnt <= (drive.low_on && !stuck) ? ((lo_cnt < SLEW) ? lo_cnt + 1 : SLEW) : ((lo_cnt > 0) ? lo_cnt - 1 : 0);
    end

    // threshold at half charge, so turn-off is slower than turn-on
    assign high_gate_ok = (hi_cnt >= 2);
    assign low_gate_ok  = (lo_cnt >= 2);
endmodule // hb_fet_model

// ---- verif/testbench.sv ----
// self-checking bench for the half-bridge protection supervisor
`timescale 1ns/10ps
`include "hb_prot_cfg.svh"
module testbench;
    logic                clk      = 1'b0;
    logic                rst_n    = 1'b0;
    logic                psel     = 1'b0;
    logic                penable  = 1'b0;
    logic                pwrite   = 1'b0;
    logic [11:0]         paddr    = 12'h000;
    logic [31:0]         pwdata   = 32'h0;
    logic                high_cmd = 1'b0;
    logic                low_cmd  = 1'b0;
    logic                stuck    = 1'b0;
    logic [2:0]          trip_sel = 3'h3;   // drain trip select code
    logic [1:0]          drain    = 2'b00;  // drain trips, high side then low side
    logic [4:0]          cause    = 5'h00;  // supply, pump, thermal, warning, sense
    logic [31:0]         prdata, rd;
    logic                pready, pslverr, err, hg_ok, lg_ok, pump_en, reg_en, fault_out_n, wdog_n;
    logic [2:0]          trip_level;
    hb_prot_pkg::drive_t drive;
    hb_prot_pkg::sense_t sense;
    int                  errors = 0;
    int                  checks = 0;

    assign sense = {cause, drain, hg_ok, lg_ok};

    hb_prot #(.OC_DEGLITCH(4), .RETRY_CYC(50), .DRIVE_CYC(8), .WDOG_UNIT(200), .PULSE_CYC(16)) u_hb_prot (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .high_cmd(high_cmd),
        .low_cmd(low_cmd), .trip_threshold_select(trip_sel), .sense(sense), .drive(drive), .trip_level(trip_level),
        .pump_enable(pump_en), .regulator_enable(reg_en), .fault_out_n(fault_out_n), .wdog_fault_out_n(wdog_n));
    hb_fet_model u_hb_fet_model (.clk(clk), .drive(drive), .stuck(stuck), .high_gate_ok(hg_ok), .low_gate_ok(lg_ok));

    // 40 mhz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // set pwm commands at a rising edge
    task automatic cmd(input logic h, input logic l);
        @(posedge clk);
        high_cmd <= h;
        low_cmd <= l;
    endtask

    // wait for the fault output level, bounded
    task automatic wait_fault(input logic lvl, input int max);
        int n;
        n = 0;
        while (fault_out_n !== lvl && n < max) begin
            @(negedge clk);
            n++;
        end
    endtask

    // reset values, unmapped access, warning flag
    task automatic t_regs;
        chk(fault_out_n, 1, "fault idle");
        chk(trip_level, 3, "trip level");
        chk({pump_en, reg_en}, 3, "supplies on");
        apb(0, `ADDR_CFG, 0);
        chk(rd, 1, "cfg reset");
        apb(0, `ADDR_CTRL, 0);
        chk(rd, 0, "wdog off");
        apb(0, 12'h00c, 0);
        chk(err, 1, "unmapped");
        cause <= 5'h02;
        apb(0, `ADDR_STATUS, 0);
        cause <= 5'h00;
        apb(0, `ADDR_STATUS, 0);
        chk(rd, 1, "warning only");
        chk(fault_out_n, 1, "warning no fault");
        apb(1, `ADDR_CTRL, 1);
        apb(0, `ADDR_STATUS, 0);
        chk(rd, 0, "clear");
        $display("test regs done");
    endtask

    // dead time per selection, then a short glitch
    task automatic t_dead;
        int exp [4] = '{5, 10, 20, 39};
        int gap;
        for (int s = 0; s < 4; s++) begin
            apb(1, `ADDR_CFG, s);
            cmd(1, 0);
            repeat (60) @(posedge clk);
            cmd(0, 1);
            gap = 0;
            while (drive.high_on !== 1'b0 && gap < 40) begin
                @(negedge clk);
                gap++;
            end
            gap = 0;
            while (drive.low_on !== 1'b1 && gap < 100) begin
                @(negedge clk);
                gap++;
            end
            chk(gap >= exp[s] && gap <= exp[s] + 6, 1, "dead time");
        end
        cmd(0, 0);
        repeat (40) @(posedge clk);
        cmd(1, 0);
        cmd(0, 0);
        repeat (10) begin
            @(negedge clk);
            chk(drive, 0, "glitch ignored");
        end
        $display("test dead done");
    endtask

    // supply, pump, thermal, sense overcurrent, gate fault
    task automatic t_fault(input int k);
        logic [31:0] bits [5] = '{32'h08, 32'h04, 32'h02, 32'h10, 32'h20};
        logic [4:0]  cz [5]   = '{5'h10, 5'h08, 5'h04, 5'h01, 5'h00};
        logic        pmp [5]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        @(posedge clk);
        stuck <= (k == 4);
        cmd(1, 0);
        repeat (60) @(posedge clk);
        cause <= cz[k];
        wait_fault(0, 30);
        @(negedge clk);
        chk(fault_out_n, 0, "fault low");
        chk(drive, 0, "bridge off");
        chk(pump_en, pmp[k], "pump");
        if (k == 2) begin
            chk(reg_en, 0, "regulator");
        end
        @(posedge clk);
        cause <= 5'h00;
        stuck <= 1'b0;
        wait_fault(1, 200);
        chk(fault_out_n, 1, "recovered");
        apb(0, `ADDR_STATUS, 0);
        chk(rd, bits[k] | 32'h80, "sticky flag");
        if (k == 0) begin
            apb(0, `ADDR_CFG, 0);
            chk(rd, 3, "cfg kept");
        end
        apb(1, `ADDR_CTRL, 1);
        apb(0, `ADDR_STATUS, 0);
        chk(rd, 0, "cleared");
        cmd(0, 0);
        $display("test fault %0d done", k);
    endtask

    // drain trip: short trip ignored, long trip cuts the bridge, top code disables
    task automatic t_drain;
        cmd(1, 0);
        repeat (60) @(posedge clk);
        drain <= 2'b10;
        repeat (3) @(posedge clk);
        drain <= 2'b00;
        repeat (4) @(negedge clk);
        chk(fault_out_n, 1, "short trip");
        @(posedge clk);
        drain <= 2'b10;
        wait_fault(0, 10);
        @(negedge clk);
        chk(drive, 0, "drain oc");
        @(posedge clk);
        trip_sel <= 3'h5;
        wait_fault(1, 200);
        repeat (60) @(posedge clk);
        chk({drive, trip_level, fault_out_n}, 6'h2b, "monitor off");
        apb(0, `ADDR_STATUS, 0);
        chk(rd, 32'h90, "oc flag");
        apb(1, `ADDR_CTRL, 1);
        drain <= 2'b00;
        trip_sel <= 3'h3;
        cmd(0, 0);
        $display("test drain done");
    endtask

    // watchdog serviced twice, then left to expire
    task automatic t_wdog;
        int n;
        apb(1, `ADDR_CFG, 1);
        cmd(1, 0);
        apb(1, `ADDR_CTRL, 2);
        repeat (2) begin
            repeat (150) @(posedge clk);
            apb(0, `ADDR_STATUS, 0);
        end
        chk(wdog_n, 1, "serviced");
        n = 0;
        while (wdog_n !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(n >= 180 && n <= 215, 1, "expiry");
        n = 0;
        while (wdog_n === 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(n, 16, "pulse length");
        chk(fault_out_n, 0, "wdog fault");
        chk(drive, 0, "halted");
        apb(0, `ADDR_CTRL, 0);
        chk(rd, 0, "enable cleared");
        apb(0, `ADDR_STATUS, 0);
        chk(rd, 32'hc0, "timeout flag");
        apb(1, `ADDR_CTRL, 1);
        wait_fault(1, 20);
        repeat (30) @(posedge clk);
        chk(drive, 2, "resumed");
        cmd(0, 0);
        $display("test wdog done");
    endtask

    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        chk(fault_out_n, 0, "reset fault");
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        t_regs();
        t_dead();
        for (int k = 0; k < 5; k++) begin
            t_fault(k);
        end
        t_drain();
        t_wdog();
        report_and_stop();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule // testbench
